/* File: verilog/ptc_timer.v */
// Two-channel 16-bit PWM timer with six compare/capture circuits per channel
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ptc_timer_consts.vh"
// Functional notes
// - Two independent channels, each with counter, clock select and six circuits.
// - 16-bit up/down counter clocked by selectable source and divider per channel.
// - Up, down or up/down counting, each in single-cycle or repeat mode.
// - Six circuits per channel, each individually compare or capture.
// - Compare match raises flag or DMA request and drives PWM output.
// - Capture latches counter on pin or software trigger, raises flag or DMA.
// - Mode bit 0 selects compare, 1 selects capture.
// - Pair members may be in different modes.
// - Compare circuit has waveform source, output mode, polarity and buffer mode.
// - Capture circuit has sync select, trigger source and trigger edge.
// - Compare pin drives low initially; capture pin is input; clock pin input.
// - Sleep clock stop freezes channel with state intact, resumes afterwards.
// - Debug freezes channel unless run-in-debug is set.
// - External clock counts rising edges, inverted selection counts falling edges.
// - Interrupt flags clear by writing 1; cleared before enables are set.
// - DMA requests gated by max/zero enable and per-circuit enable.
// - Counter reset clears to zero, or loads max value in down mode.
// - Counting up, counter wraps to zero when exceeding max value.
// - Counter reaching compare value asserts match and sets that flag.
module ptc_timer (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] extClkIn,
  input wire [11:0] capTrigIn,
  output wire [11:0] waveOut,
  output wire [11:0] waveOutEn,
  input wire sleepMode,
  input wire sleepClockStop,
  input wire debugMode,
  output wire [1:0] irqReq,
  output wire [1:0] dmaMaxZeroReq,
  output wire [11:0] dmaCircuitReq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Low bits set for a divide by two to the power d
  function [15:0] ptc_mask;
    input [3:0] d;
    begin
      ptc_mask = ~(16'hffff << d);
    end
  endfunction

  // Flat circuit index from channel and circuit number
  function [3:0] ptc_idx;
    input ch;
    input [2:0] m;
    begin
      ptc_idx = ch ? {1'b0, m} + 4'h6 : {1'b0, m};
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  // two channels, six circuits each
  reg [8:0] clkCfg_r [0:1];
  reg [6:0] ctl_r [0:1];
  reg [15:0] max_r [0:1];
  reg [15:0] cnt_r [0:1];
  reg [15:0] pre_r [0:1];
  reg [1:0] dummy_r [0:1];
  reg [7:0] irqF_r [0:1];
  reg [7:0] irqE_r [0:1];
  reg [6:0] dmaE_r [0:1];
  reg [13:0] ccCtl_r [0:11];
  reg [15:0] ccr_r [0:11];
  reg [15:0] cmp_r [0:11];
  reg [1:0] up_r;
  reg [11:0] wave_r, waveO_r, trigPrev_r, pend_r, swTrig_r, dmaCc_r;
  reg [1:0] irq_r, dmaMz_r;
  reg [3:0] extS1_r, extS2_r, extS3_r;
  reg [11:0] capS1_r, capS2_r, capS3_r;
  reg [31:0] prdata_r;
  reg err_r;
  integer c, m, k;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Third stage only serves the clock edge detectors; capS3_r is never read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extS1_r <= 4'h0;
      extS2_r <= 4'h0;
      extS3_r <= 4'h0;
      capS1_r <= 12'h000;
      capS2_r <= 12'h000;
      capS3_r <= 12'h000;
    end else begin
      extS1_r <= extClkIn;
      extS2_r <= extS1_r;
      extS3_r <= extS2_r;
      capS1_r <= capTrigIn;
      capS2_r <= capS1_r;
      capS3_r <= capS2_r;
    end
  end

  wire [3:0] extRise = extS2_r & ~extS3_r;
  wire [3:0] extFall = ~extS2_r & extS3_r;
  wire sleepHold = sleepMode & sleepClockStop;

  // ****************************************
  // Count clock selection and gating
  // ****************************************
  reg [1:0] active, srcTick, isExt, preHit, runGate, cntTick;
  // Freeze on sleep or debug holds every counter and divider
  // Own loop index: a shared one would wake the other processes forever
  always @* begin : pClkSel
    integer c;
    for (c = 0; c < `PTC_CH_NUM; c = c + 1) begin
      active[c] = ~sleepHold & ~(debugMode & ~clkCfg_r[c][`PTC_CLK_DBG]);
      case (clkCfg_r[c][`PTC_CLK_SRC])
        3'h1: srcTick[c] = extRise[2 * c];
        3'h2: srcTick[c] = extFall[2 * c];
        3'h3: srcTick[c] = extRise[2 * c + 1];
        3'h4: srcTick[c] = extFall[2 * c + 1];
        default: srcTick[c] = 1'b1;
      endcase
      isExt[c] = (clkCfg_r[c][`PTC_CLK_SRC] != 3'h0) && (clkCfg_r[c][`PTC_CLK_SRC] <= 3'h4);
      preHit[c] = (pre_r[c] & ptc_mask(clkCfg_r[c][`PTC_CLK_DIV])) == ptc_mask(clkCfg_r[c][`PTC_CLK_DIV]);
      runGate[c] = ctl_r[c][`PTC_CTL_EN] & ctl_r[c][`PTC_CTL_RUN] & active[c];
      cntTick[c] = runGate[c] & srcTick[c] & preHit[c] & ~(isExt[c] & (dummy_r[c] != `PTC_EXT_DUMMY));
    end
  end

  // ****************************************
  // Counter next state
  // ****************************************
  reg [15:0] cntNxt [0:1];
  reg [1:0] upNxt, stopNow, evMax, evZero;
  always @* begin : pCntNext
    integer c;
    for (c = 0; c < `PTC_CH_NUM; c = c + 1) begin
      cntNxt[c] = cnt_r[c];
      upNxt[c] = up_r[c];
      stopNow[c] = 1'b0;
      if (ctl_r[c][`PTC_CTL_DIR] == `PTC_DIR_DOWN) begin
        upNxt[c] = 1'b0;
        if (cnt_r[c] == 16'h0000) begin
          cntNxt[c] = max_r[c];
          stopNow[c] = ctl_r[c][`PTC_CTL_ONE];
        end else begin
          cntNxt[c] = cnt_r[c] - 16'h0001;
        end
      end else if (ctl_r[c][`PTC_CTL_DIR] == `PTC_DIR_UPDN && !up_r[c]) begin
        if (cnt_r[c] == 16'h0000) begin
          stopNow[c] = ctl_r[c][`PTC_CTL_ONE];
          upNxt[c] = ~stopNow[c];
          cntNxt[c] = (stopNow[c] || max_r[c] == 16'h0000) ? 16'h0000 : 16'h0001;
        end else begin
          cntNxt[c] = cnt_r[c] - 16'h0001;
        end
      end else if (ctl_r[c][`PTC_CTL_DIR] == `PTC_DIR_UPDN && cnt_r[c] == max_r[c]) begin
        upNxt[c] = 1'b0;
        cntNxt[c] = (max_r[c] == 16'h0000) ? 16'h0000 : cnt_r[c] - 16'h0001;
      end else begin
        upNxt[c] = 1'b1;
        if (cnt_r[c] >= max_r[c]) begin
          cntNxt[c] = 16'h0000;
          stopNow[c] = ctl_r[c][`PTC_CTL_ONE] & (ctl_r[c][`PTC_CTL_DIR] != `PTC_DIR_UPDN);
        end else begin
          cntNxt[c] = cnt_r[c] + 16'h0001;
        end
      end
      evMax[c] = cntTick[c] & (cntNxt[c] == max_r[c]);
      evZero[c] = cntTick[c] & (cntNxt[c] == 16'h0000);
    end
  end

  // ****************************************
  // Circuit events and waveforms
  // ****************************************
  reg [11:0] match, trigSel, capHit, ccEv, waveNxt, matchSel;
  always @* begin : pCircuit
    integer c, m, k;
    for (c = 0; c < `PTC_CH_NUM; c = c + 1) begin
      for (m = 0; m < `PTC_CC_NUM; m = m + 1) begin
        k = c * 6 + m;
        match[k] = cntTick[c] & ~ccCtl_r[k][`PTC_CC_MODE] & (cntNxt[c] == cmp_r[k]);
        case (ccCtl_r[k][`PTC_CC_TSRC])
          2'h0: trigSel[k] = capS2_r[k];
          2'h1: trigSel[k] = ~capS2_r[k];
          2'h2: trigSel[k] = swTrig_r[k];
          default: trigSel[k] = 1'b0;
        endcase
        capHit[k] = ctl_r[c][`PTC_CTL_EN] & active[c] & ccCtl_r[k][`PTC_CC_MODE] &
                    ((ccCtl_r[k][12] & trigSel[k] & ~trigPrev_r[k]) |
                     (ccCtl_r[k][13] & ~trigSel[k] & trigPrev_r[k]));
      end
    end
    for (k = 0; k < 12; k = k + 1) begin
      c = (k >= 6) ? 1 : 0;
      if (ccCtl_r[k][`PTC_CC_MODE]) begin
        // capture moment, sync waits for a count tick
        ccEv[k] = ccCtl_r[k][`PTC_CC_SYNC] ? (pend_r[k] | capHit[k]) & cntTick[c] : capHit[k];
      end else begin
        ccEv[k] = match[k];
      end
      // waveform source takes pair partner too
      matchSel[k] = match[k] | (ccCtl_r[k][`PTC_CC_WSRC] & match[k ^ 1]);
      waveNxt[k] = wave_r[k];
      case (ccCtl_r[k][`PTC_CC_OMD])
        3'h0: waveNxt[k] = 1'b0;
        3'h1: waveNxt[k] = wave_r[k] | matchSel[k];
        3'h2: waveNxt[k] = wave_r[k] & ~matchSel[k];
        3'h4: waveNxt[k] = matchSel[k] ? 1'b1 : (evZero[c] ? 1'b0 : wave_r[k]);
        3'h5: waveNxt[k] = matchSel[k] ? 1'b0 : (evZero[c] ? 1'b1 : wave_r[k]);
        default: waveNxt[k] = wave_r[k] ^ matchSel[k];
      endcase
      if (ccCtl_r[k][`PTC_CC_MODE] || !ctl_r[c][`PTC_CTL_EN]) begin
        waveNxt[k] = 1'b0;
      end
    end
  end

  // ****************************************
  // APB decode and readback
  // ****************************************
  wire ch = paddr[7];
  wire [6:0] off = paddr[6:0];
  wire [3:0] ccIdx = ptc_idx(ch, off[4:2]);
  wire ccSlot = (off[4:2] < 3'h6) && (off[6:5] == `PTC_A_CCCTL || off[6:5] == `PTC_A_CCR);
  wire mapped = (paddr[1:0] == 2'h0) && ((off <= `PTC_A_SWTRG) || ccSlot);
  wire wrEn = psel & penable & pwrite & mapped;
  reg [31:0] rdVal;
  always @* begin
    rdVal = 32'h00000000;
    if (off == `PTC_A_CLK) begin
      rdVal[8:0] = clkCfg_r[ch];
    end else if (off == `PTC_A_CTL) begin
      rdVal[6:0] = ctl_r[ch] & 7'h7b;
    end else if (off == `PTC_A_MAX) begin
      rdVal[15:0] = max_r[ch];
    end else if (off == `PTC_A_CNT) begin
      rdVal = {14'h0000, up_r[ch], ctl_r[ch][`PTC_CTL_RUN], cnt_r[ch]};
    end else if (off == `PTC_A_IRQF) begin
      rdVal[7:0] = irqF_r[ch];
    end else if (off == `PTC_A_IRQE) begin
      rdVal[7:0] = irqE_r[ch];
    end else if (off == `PTC_A_DMAE) begin
      rdVal[6:0] = dmaE_r[ch];
    end else if (ccSlot && off[6:5] == `PTC_A_CCCTL) begin
      rdVal[13:0] = ccCtl_r[ccIdx];
    end else if (ccSlot) begin
      rdVal[15:0] = ccr_r[ccIdx];
    end
  end

  // Zero-wait slave: data latched in setup, so prdata is a flop
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;
  assign prdata = prdata_r;
  assign irqReq = irq_r;
  assign dmaMaxZeroReq = dmaMz_r;
  assign dmaCircuitReq = dmaCc_r;
  assign waveOut = waveO_r;

  // pin drives only in compare mode
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : gOe
      assign waveOutEn[g] = ctl_r[g / 6][`PTC_CTL_EN] & ~ccCtl_r[g][`PTC_CC_MODE];
    end
  endgenerate

  // ****************************************
  // Registers, counters and circuits
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (c = 0; c < 2; c = c + 1) begin
        clkCfg_r[c] <= 9'h000;
        ctl_r[c] <= 7'h00;
        max_r[c] <= `PTC_MAX_RST;
        cnt_r[c] <= 16'h0000;
        pre_r[c] <= 16'h0000;
        dummy_r[c] <= 2'h0;
        irqF_r[c] <= 8'h00;
        irqE_r[c] <= 8'h00;
        dmaE_r[c] <= 7'h00;
      end
      for (k = 0; k < 12; k = k + 1) begin
        ccCtl_r[k] <= 14'h0000;
        ccr_r[k] <= 16'h0000;
        cmp_r[k] <= 16'h0000;
      end
      up_r <= 2'h3;
      {wave_r, waveO_r, trigPrev_r, pend_r, swTrig_r, dmaCc_r} <= 72'h0;
      irq_r <= 2'h0;
      dmaMz_r <= 2'h0;
      prdata_r <= 32'h00000000;
      err_r <= 1'b0;
    end else begin
      if (psel && !penable) begin
        prdata_r <= mapped ? rdVal : 32'h00000000; // Refused reads return zero
        err_r <= ~mapped;
      end
      swTrig_r <= 12'h000;
      trigPrev_r <= trigSel;
      wave_r <= waveNxt;
      for (k = 0; k < 12; k = k + 1) begin
        waveO_r[k] <= waveNxt[k] & ~ccCtl_r[k][`PTC_CC_MODE] ? ~ccCtl_r[k][`PTC_CC_INV] : ccCtl_r[k][`PTC_CC_INV];
        if (ccCtl_r[k][`PTC_CC_MODE] || !ctl_r[k / 6][`PTC_CTL_EN]) begin
          waveO_r[k] <= 1'b0;
        end
      end
      if (wrEn && off == `PTC_A_CLK) clkCfg_r[ch] <= pwdata[8:0];
      if (wrEn && off == `PTC_A_CTL) ctl_r[ch] <= pwdata[6:0] & 7'h7b;
      if (wrEn && off == `PTC_A_MAX) max_r[ch] <= pwdata[15:0];
      if (wrEn && off == `PTC_A_IRQE) irqE_r[ch] <= pwdata[7:0];
      if (wrEn && off == `PTC_A_DMAE) dmaE_r[ch] <= pwdata[6:0];
      if (wrEn && off == `PTC_A_SWTRG) swTrig_r[ccIdx - {1'b0, off[4:2]} +: 6] <= pwdata[5:0];
      if (wrEn && ccSlot && off[6:5] == `PTC_A_CCCTL) ccCtl_r[ccIdx] <= pwdata[13:0];
      if (wrEn && ccSlot && off[6:5] == `PTC_A_CCR) ccr_r[ccIdx] <= pwdata[15:0];
      for (c = 0; c < 2; c = c + 1) begin
        // Divider and dummy edges advance only while running
        if (!runGate[c] && active[c]) begin
          dummy_r[c] <= 2'h0;
        end else if (runGate[c] && srcTick[c]) begin
          if (isExt[c] && dummy_r[c] != `PTC_EXT_DUMMY) dummy_r[c] <= dummy_r[c] + 2'h1;
          else pre_r[c] <= preHit[c] ? 16'h0000 : pre_r[c] + 16'h0001;
        end
        if (wrEn && off == `PTC_A_CTL && ch == c && pwdata[`PTC_CTL_RST]) begin
          cnt_r[c] <= (pwdata[5:4] == `PTC_DIR_DOWN) ? max_r[c] : 16'h0000;
          up_r[c] <= pwdata[5:4] != `PTC_DIR_DOWN;
          pre_r[c] <= 16'h0000;
        end else if (cntTick[c]) begin
          cnt_r[c] <= cntNxt[c];
          up_r[c] <= upNxt[c];
          if (stopNow[c]) ctl_r[c][`PTC_CTL_RUN] <= 1'b0;
        end
        // write one clears, new event wins
        irqF_r[c] <= (irqF_r[c] & ~((wrEn && off == `PTC_A_IRQF && ch == c) ? pwdata[7:0] : 8'h00)) |
                     {ccEv[c * 6 +: 6], evZero[c], evMax[c]};
        irq_r[c] <= |(irqF_r[c] & irqE_r[c]);
        dmaMz_r[c] <= dmaE_r[c][0] & (evMax[c] | evZero[c]);
        for (m = 0; m < 6; m = m + 1) begin
          k = c * 6 + m;
          dmaCc_r[k] <= dmaE_r[c][m + 1] & ccEv[k];
          if (!ctl_r[c][`PTC_CTL_RUN] || ccCtl_r[k][`PTC_CC_BUF] == 3'h0 || ccCtl_r[k][`PTC_CC_BUF] > 3'h3 ||
              (ccCtl_r[k][6] && evZero[c]) || (ccCtl_r[k][7] && evMax[c])) begin
            cmp_r[k] <= ccr_r[k];
          end
          pend_r[k] <= ccCtl_r[k][`PTC_CC_MODE] & ccCtl_r[k][`PTC_CC_SYNC] & (pend_r[k] | capHit[k]) & ~cntTick[c];
          if (ccEv[k] && ccCtl_r[k][`PTC_CC_MODE]) ccr_r[k] <= cnt_r[c];
        end
      end
    end
  end

endmodule

/* File: verilog/ptc_timer_consts.vh */
// Constants for the two-channel PWM timer with compare/capture circuits
`ifndef PTC_TIMER_CONSTS_VH
`define PTC_TIMER_CONSTS_VH
// ****************************************
// Structure
// ****************************************
`define PTC_CH_NUM 2
`define PTC_CC_NUM 6
// ****************************************
// Register offsets inside one channel window
// ****************************************
`define PTC_A_CLK 7'h00
`define PTC_A_CTL 7'h04
`define PTC_A_MAX 7'h08
`define PTC_A_CNT 7'h0c
`define PTC_A_IRQF 7'h10
`define PTC_A_IRQE 7'h14
`define PTC_A_DMAE 7'h18
`define PTC_A_SWTRG 7'h1c
`define PTC_A_CCCTL 2'h1
`define PTC_A_CCR 2'h2
// ****************************************
// Field positions
// ****************************************
`define PTC_CLK_SRC 2:0
`define PTC_CLK_DIV 7:4
`define PTC_CLK_DBG 8
`define PTC_CTL_EN 0
`define PTC_CTL_RUN 1
`define PTC_CTL_RST 2
`define PTC_CTL_DIR 5:4
`define PTC_CTL_ONE 6
`define PTC_CC_MODE 0
`define PTC_CC_WSRC 1
`define PTC_CC_OMD 4:2
`define PTC_CC_INV 5
`define PTC_CC_BUF 8:6
`define PTC_CC_SYNC 9
`define PTC_CC_TSRC 11:10
`define PTC_CC_TEDGE 13:12
`define PTC_CNT_BUSY 16
`define PTC_CNT_UP 17
// ****************************************
// Reset values and counts
// ****************************************
`define PTC_MAX_RST 16'hffff
`define PTC_EXT_DUMMY 2'h2
`define PTC_DIR_DOWN 2'h1
`define PTC_DIR_UPDN 2'h2
`endif

/* File: bench/ptc_far_side.sv */
// Far-side model: external count clock pins and capture trigger pins
`timescale 1ns/10ps
module ptc_far_side (
  output logic [3:0] extClkIn,
  output logic [11:0] capTrigIn,
  input wire core_clk
);
  // ****************************************
  // Pin drivers
  // ****************************************
  // Pins idle low; the count clock only moves inside a commanded train
  initial begin
    extClkIn = 4'h0;
    capTrigIn = 12'h000;
  end
  // edge train
  // Each level held 4 cycles so the two-flop synchroniser never misses one
  task automatic pulseExt(input int pin, input int n);
    for (int k = 0; k < n; k++) begin
      repeat (4) @(posedge core_clk);
      extClkIn[pin] <= 1'b1;
      repeat (4) @(posedge core_clk);
      extClkIn[pin] <= 1'b0;
    end
  endtask
  // One rising trigger, wide enough to pass the synchroniser
  task automatic trigCap(input int idx);
    @(posedge core_clk);
    capTrigIn[idx] <= 1'b1;
    repeat (4) @(posedge core_clk);
    capTrigIn[idx] <= 1'b0;
  endtask
endmodule

/* File: bench/ptc_timer_asserts.sv */
// Assertion checker for the timer's bus, pin and request ports
`timescale 1ns/10ps
module ptc_timer_asserts (
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [11:0] waveOut,
  input wire [11:0] waveOutEn,
  input wire sleepMode,
  input wire sleepClockStop,
  input wire [1:0] irqReq,
  input wire [1:0] dmaMaxZeroReq,
  input wire [11:0] dmaCircuitReq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Sleep freeze with no write in flight, since a write may change outputs
  wire frozenQuiet = sleepMode & sleepClockStop & ~(psel & pwrite);
  // Bus answer and refusal
  AST_READY: assert property (pready == 1'b1)
    else $error("pready dropped");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  AST_ERR_DATA: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  AST_RDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without a setup cycle");
  // Pins and requests
  AST_RST_OUT: assert property ($rose(rst_n) |-> waveOut == 12'h000 && irqReq == 2'h0 && dmaCircuitReq == 12'h000)
    else $error("outputs not idle after reset");
  AST_WAVE_IDLE: assert property ((waveOut & ~waveOutEn & ~$past(waveOutEn)) == 12'h000)
    else $error("undriven waveform pin high");
  AST_FRZ_DMA: assert property (frozenQuiet [*6] |-> dmaMaxZeroReq == 2'h0 && dmaCircuitReq == 12'h000)
    else $error("request while frozen");
  AST_FRZ_HOLD: assert property (frozenQuiet [*4] |-> $stable(irqReq) && $stable(waveOut))
    else $error("outputs moved while frozen");
  AST_DMA_FROZEN: assert property (|dmaCircuitReq |-> !$past(sleepMode && sleepClockStop))
    else $error("circuit request after a frozen cycle");
  // Main scenarios reached
  cover property (pslverr);
  cover property (|dmaCircuitReq);
  cover property ($rose(irqReq[0]));
endmodule
bind ptc_timer ptc_timer_asserts i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .waveOut(waveOut), .waveOutEn(waveOutEn),
  .sleepMode(sleepMode), .sleepClockStop(sleepClockStop), .irqReq(irqReq),
  .dmaMaxZeroReq(dmaMaxZeroReq), .dmaCircuitReq(dmaCircuitReq)
);

/* File: bench/ptc_timer_test.sv */
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/10ps
`include "ptc_timer_consts.vh"
module ptc_timer_test;
  // ****************************************
  // Wiring
  // ****************************************
  localparam logic [7:0] CLKR = {1'b0, `PTC_A_CLK};
  localparam logic [7:0] CTL = {1'b0, `PTC_A_CTL};
  localparam logic [7:0] MAXR = {1'b0, `PTC_A_MAX};
  localparam logic [7:0] CNT = {1'b0, `PTC_A_CNT};
  localparam logic [7:0] IRQF = {1'b0, `PTC_A_IRQF};
  localparam logic [7:0] DMAE = {1'b0, `PTC_A_DMAE};
  logic core_clk, rst_n, psel, penable, pwrite, sleepMode, sleepClockStop, debugMode, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, a, b;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [3:0] extClkIn;
  wire [11:0] capTrigIn, waveOut, waveOutEn, dmaCircuitReq;
  wire [1:0] irqReq, dmaMaxZeroReq;
  int n_fail, comparisons, nDma0, nMz, d0;
  ptc_timer i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extClkIn(extClkIn), .capTrigIn(capTrigIn), .waveOut(waveOut),
    .waveOutEn(waveOutEn), .sleepMode(sleepMode), .sleepClockStop(sleepClockStop),
    .debugMode(debugMode), .irqReq(irqReq), .dmaMaxZeroReq(dmaMaxZeroReq), .dmaCircuitReq(dmaCircuitReq));
  ptc_far_side i_far (.extClkIn(extClkIn), .capTrigIn(capTrigIn), .core_clk(core_clk));
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Request pulse counters for the gating checks
  always @(posedge core_clk) begin
    if (dmaCircuitReq[0] === 1'b1) nDma0 <= nDma0 + 1;
    if (dmaMaxZeroReq[0] === 1'b1) nMz <= nMz + 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  // One APB transfer; waits on pready rather than assuming zero wait states
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d, output logic [31:0] q,
    output logic er);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge core_clk);
    end
    if (k == 20) n_fail++;
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    xfer(ad, 1'b1, d, q, er);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic er;
    xfer(ad, 1'b0, 32'h0, q, er);
    chk(q & m, exp);
  endtask
  // Bounded wait for one circuit request pulse
  task automatic waitDma(input int i);
    int k;
    k = 0;
    while (dmaCircuitReq[i] !== 1'b1 && k < 200) begin
      k++;
      @(posedge core_clk);
      #1;
    end
    chk({31'h0, dmaCircuitReq[i]}, 32'h1);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far beyond the 700 or so cycles the tests need
  initial begin
    #40000;
    n_fail++;
    summarize;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst_n, psel, penable, pwrite, sleepMode, sleepClockStop, debugMode} = 7'h00;
    {paddr, pwdata, n_fail, comparisons, nDma0, nMz} = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk(MAXR, 32'hffff_ffff, `PTC_MAX_RST);
    rdChk(CNT, 32'h3_ffff, 32'h2_0000);
    xfer(8'h7c, 1'b0, 32'h0, a, e);
    chk({31'h0, e}, 32'h1);
    // Run without enable must stay dead
    wr(CTL, 32'h2);
    repeat (20) @(posedge core_clk);
    rdChk(CNT, 32'hffff, 32'h0);
    rdChk(IRQF, 32'hff, 32'h0);
    // One-shot up to MAX 5, wraps to zero and stops
    wr(MAXR, 32'h5);
    wr(CTL, 32'h1);
    wr(IRQF, 32'hff);
    wr(CTL, 32'h5);
    wr(CTL, 32'h43);
    repeat (40) @(posedge core_clk);
    rdChk(CNT, 32'hffff, 32'h0);
    rdChk(IRQF, 32'h3, 32'h3);
    wr(IRQF, 32'h3);
    rdChk(IRQF, 32'h3, 32'h0);
    wr(CTL, 32'h15);
    rdChk(CNT, 32'hffff, 32'h5);
    wr(CTL, 32'h25);
    rdChk(CNT, 32'hffff, 32'h0);
    // Circuit 0 compare, 1 pin capture, 3 software capture
    // init order
    wr(8'h20, 32'h4);
    wr(8'h24, 32'h1001);
    wr(8'h2c, 32'h3801);
    wr(MAXR, 32'h9);
    wr(8'h40, 32'h3);
    wr(IRQF, 32'hff);
    wr(8'h14, 32'h4);
    wr(DMAE, 32'h16);
    wr(CTL, 32'h5);
    wr(CTL, 32'h3);
    waitDma(0);
    repeat (2) @(posedge core_clk);
    #1;
    chk({30'h0, irqReq}, 32'h1);
    chk({31'h0, waveOut[0]}, 32'h1);
    rdChk(IRQF, 32'h4, 32'h4);
    fork
      i_far.trigCap(1);
      waitDma(1);
    join
    xfer(8'h44, 1'b0, 32'h0, a, e);
    chk({31'h0, a <= 32'h9}, 32'h1);
    fork
      wr(8'h1c, 32'h8);
      waitDma(3);
    join
    // Gating of both request kinds
    wr(DMAE, 32'h0);
    repeat (2) @(posedge core_clk);
    d0 = nDma0;
    repeat (40) @(posedge core_clk);
    chk(nDma0 - d0, 32'h0);
    chk(nMz, 32'h0);
    wr(DMAE, 32'h1);
    repeat (40) @(posedge core_clk);
    chk({31'h0, nMz > 0}, 32'h1);
    for (int inv = 0; inv < 2; inv++) begin
      wr(8'h20, inv << 5);
      repeat (3) @(posedge core_clk);
      #1;
      chk({31'h0, waveOut[0]}, inv);
    end
    // Sleep and debug freezes; 13 cycles avoids the 10-cycle period
    sleepMode <= 1'b1;
    sleepClockStop <= 1'b1;
    xfer(CNT, 1'b0, 32'h0, a, e);
    repeat (13) @(posedge core_clk);
    rdChk(CNT, 32'h3_ffff, a);
    {sleepMode, sleepClockStop, debugMode} <= 3'b001;
    xfer(CNT, 1'b0, 32'h0, a, e);
    repeat (13) @(posedge core_clk);
    rdChk(CNT, 32'h3_ffff, a);
    wr(CLKR, 32'h100);
    xfer(CNT, 1'b0, 32'h0, a, e);
    repeat (13) @(posedge core_clk);
    xfer(CNT, 1'b0, 32'h0, b, e);
    chk({31'h0, a !== b}, 32'h1);
    debugMode <= 1'b0;
    // Channel 1 on each external source: 2 dummy edges then 3 counted
    for (int src = 1; src < 5; src++) begin
      wr(8'h84, 32'h0);
      wr(8'h80, src);
      wr(8'h84, 32'h5);
      wr(8'h84, 32'h3);
      i_far.pulseExt(2 + (src - 1) / 2, 5);
      repeat (8) @(posedge core_clk);
      rdChk(8'h8c, 32'hffff, 32'h3);
    end
    // Divide by two on channel 1, up then down: 11 ticks in 22 cycles
    wr(8'h80, 32'h10);
    for (int dn = 0; dn < 2; dn++) begin
      wr(8'h84, 32'h5 | dn << 4);
      wr(8'h84, 32'h3 | dn << 4);
      repeat (20) @(posedge core_clk);
      wr(8'h84, 32'h1 | dn << 4);
      rdChk(8'h8c, 32'h3_ffff, dn ? 32'hfff4 : 32'h2_000b);
    end
    summarize;
  end
endmodule
